// ===== src/sfrpe_top.v
// Serial flash read, program, erase and sleep sequencer
`timescale 1ns/1ps
`include "sfrpe_regs.vh"
module sfrpe_top
#(
    parameter AW         = 20,
    parameter PROG_CYC   = `SFRPE_T_PROG_US * `SFRPE_CLK_MHZ,
    parameter SECT_CYC   = `SFRPE_T_SECT_US * `SFRPE_CLK_MHZ,
    parameter BULK_CYC   = `SFRPE_T_BULK_US * `SFRPE_CLK_MHZ,
    parameter SECT_BITS  = 4
)
(
    input  wire       clk_in,
    input  wire       reset_in,
    input  wire       sel_n_in,
    input  wire       sclk_in,
    input  wire       sdi_in,
    input  wire [2:0] area_guard_bits_in,
    output reg        sdo_out,
    output reg        sdo_oe_out,
    output reg        cycle_active_flag_out,
    output reg        write_unlock_latch_out,
    output reg        sleep_out,
    output reg        standby_out
);
    localparam DEPTH = (1 << AW);
    localparam ST_IDLE = 3'd0;
    localparam ST_PROG = 3'd1;
    localparam ST_SECT = 3'd2;
    localparam ST_BULK = 3'd3;
    localparam ST_SLP  = 3'd4;

    reg [7:0]    mem [0:DEPTH-1];
    reg [7:0]    pbuf [0:255];
    reg [255:0]  pmask;

    // Array leaves the factory fully erased
    integer k;
    initial
    begin
        for (k = 0; k < DEPTH; k = k + 1)
            mem[k] = 8'hff;
    end

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Serial clock half period must span at least four clk_in cycles
    wire sel_n;
    wire sclk;
    wire sd_s;

    sfrpe_sync u_sel
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .async_in  (sel_n_in),
        .init_in   (1'b1),
        .level_out (sel_n)
    );

    sfrpe_sync u_clk
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .async_in  (sclk_in),
        .init_in   (1'b0),
        .level_out (sclk)
    );

    sfrpe_sync u_sdi
    (
        .clk_in    (clk_in),
        .reset_in  (reset_in),
        .async_in  (sdi_in),
        .init_in   (1'b0),
        .level_out (sd_s)
    );

    // ----------------------------------------
    // Edge detection on the synchronised pins
    // ----------------------------------------
    reg sclk_d;
    reg sel_d;
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            sclk_d <= 1'b0;
            sel_d <= 1'b1;
        end
        else
        begin
            sclk_d <= sclk;
            sel_d <= sel_n;
        end
    end
    wire rise = sclk & ~sclk_d & ~sel_n;
    wire fall = ~sclk & sclk_d & ~sel_n;
    wire sel_rise = sel_n & ~sel_d;

    // ----------------------------------------
    // Shift state
    // ----------------------------------------
    reg [7:0]    opcode;
    reg [7:0]    sh;
    reg [2:0]    bitc;
    reg [15:0]   bytec;
    reg [23:0]   addr;
    reg [7:0]    pcol;
    reg [7:0]    obyte;
    reg          reading;
    reg          rejected;
    reg [2:0]    st;
    reg [31:0]   cnt;
    reg [23:0]   wipe_addr;
    reg [AW:0]   clr_idx;

    wire [7:0] shn = {sh[6:0], sd_s}; // [R24]
    wire busy = (st == ST_PROG) || (st == ST_SECT) || (st == ST_BULK);
    wire [2:0] g = area_guard_bits_in;
    wire [SECT_BITS-1:0] sect = addr[AW-1 -: SECT_BITS];
    // ----------------------------------------
    // Area guard decode
    // ----------------------------------------
    // Guard level n protects the top 2^(n-1) of 16 sectors, five and up protect all
    reg  [4:0] guarded_from;
    always @*
    begin
        case (g)
            3'd0:    guarded_from = 5'd16;
            3'd1:    guarded_from = 5'd15;
            3'd2:    guarded_from = 5'd14;
            3'd3:    guarded_from = 5'd12;
            3'd4:    guarded_from = 5'd8;
            default: guarded_from = 5'd0;
        endcase
    end
    wire addr_guarded = ({1'b0, sect} >= guarded_from);
    wire byte_edge = (bitc == 3'd0);
    wire [AW-1:0] next_raddr = addr[AW-1:0] + 1'b1;
    integer i;

    // ----------------------------------------
    // Opcode screening and start conditions
    // ----------------------------------------
    // Screened at the opcode's eighth bit, so a refused frame never reaches decode
    wire op_refused = (sleep_out && shn != `SFRPE_OP_WAKE) ||
                      (busy && (shn == `SFRPE_OP_FAST_READ || shn == `SFRPE_OP_SLEEP));
    wire op_wake    = (shn == `SFRPE_OP_WAKE) && !busy;
    wire op_unlock  = (shn == `SFRPE_OP_UNLOCK) && !busy && !sleep_out;
    // A select rise off a byte boundary drops the command
    wire frame_ok   = sel_rise && !rejected && !busy && byte_edge && !sleep_out;
    wire go_prog    = write_unlock_latch_out && (opcode == `SFRPE_OP_PAGE_WRITE) &&
                      (bytec >= 16'd5) && !addr_guarded;
    wire go_sect    = write_unlock_latch_out && (opcode == `SFRPE_OP_ZONE_WIPE) &&
                      (bytec == 16'd4) && !addr_guarded;
    wire go_bulk    = write_unlock_latch_out && (opcode == `SFRPE_OP_FULL_WIPE) &&
                      (bytec == 16'd1) && (g == 3'd0);
    wire go_sleep   = (opcode == `SFRPE_OP_SLEEP) && (bytec == 16'd1);

    // ----------------------------------------
    // Status levels
    // ----------------------------------------
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            cycle_active_flag_out <= 1'b0;
            standby_out <= 1'b1;
        end
        else
        begin
            // Sleep entry delay is not standby, so standby never overlaps sleep
            standby_out <= sel_n & ~busy & ~sleep_out & (st != ST_SLP); // [R23]
            cycle_active_flag_out <= busy; // [R14]
        end
    end

    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            opcode <= 8'h00;
            sh <= 8'h00;
            bitc <= 3'd0;
            bytec <= 16'd0;
            addr <= 24'h000000;
            pcol <= 8'h00;
            obyte <= 8'h00;
            reading <= 1'b0;
            rejected <= 1'b0;
            st <= ST_IDLE;
            cnt <= 32'd0;
            wipe_addr <= 24'h000000;
            clr_idx <= {(AW+1){1'b0}};
            pmask <= 256'd0;
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
            write_unlock_latch_out <= 1'b0;
            sleep_out <= 1'b0; // [R22]
        end
        else
        begin
            // Each new frame restarts byte counting and forgets leftovers
            if (!sel_n && sel_d)
            begin
                bitc <= 3'd0;
                bytec <= 16'd0;
                reading <= 1'b0;
                rejected <= 1'b0;
                pmask <= 256'd0;
            end
            // ----------------------------------------
            // Input shifting on rising serial clock
            // ----------------------------------------
            if (rise && !reading)
            begin
                sh <= shn; // [R1]
                bitc <= bitc + 3'd1;
                if (bitc == 3'd7)
                begin
                    bytec <= bytec + 16'd1;
                    if (bytec == 16'd0)
                    begin
                        opcode <= shn;
                        if (op_refused)
                            rejected <= 1'b1; // [R5] [R22]
                        if (op_wake)
                            sleep_out <= 1'b0; // [R22]
                        if (op_unlock)
                            write_unlock_latch_out <= 1'b1; // [R6]
                    end
                    else if (bytec <= 16'd3)
                    begin
                        addr <= {addr[15:0], shn}; // [R24]
                        if (bytec == 16'd3)
                            pcol <= shn;
                    end
                    else if (opcode == `SFRPE_OP_FAST_READ && bytec == 16'd4 && !rejected)
                    begin
                        reading <= 1'b1; // [R1]
                        obyte <= mem[addr[AW-1:0]];
                    end
                    else if (opcode == `SFRPE_OP_PAGE_WRITE && !busy)
                    begin
                        pbuf[pcol] <= shn; // [R10]
                        pmask[pcol] <= 1'b1; // [R11]
                        pcol <= pcol + 8'd1; // [R9]
                    end
                end
            end
            // ----------------------------------------
            // Read output on falling serial clock
            // ----------------------------------------
            if (reading && fall)
            begin
                sdo_oe_out <= 1'b1;
                sdo_out <= obyte[~bitc]; // [R2]
                bitc <= bitc + 3'd1;
                if (bitc == 3'd7)
                begin
                    addr <= addr + 24'd1; // [R3]
                    obyte <= mem[next_raddr];
                end
            end
            if (sel_n)
                sdo_oe_out <= 1'b0; // [R4]
            // ----------------------------------------
            // Select rise decodes the command
            // ----------------------------------------
            if (frame_ok)
            begin
                if (go_prog)
                begin
                    st <= ST_PROG; // [R6] [R12] [R13] [R16]
                    cnt <= PROG_CYC;
                end
                else if (go_sect)
                begin
                    st <= ST_SECT; // [R6] [R18]
                    cnt <= SECT_CYC;
                    clr_idx <= {(AW+1){1'b0}};
                    wipe_addr <= addr;
                end
                else if (go_bulk)
                begin
                    st <= ST_BULK; // [R6] [R19] [R20]
                    cnt <= BULK_CYC;
                    clr_idx <= {(AW+1){1'b0}};
                end
                else if (go_sleep)
                begin
                    st <= ST_SLP; // [R21]
                    cnt <= `SFRPE_SLEEP_CYC;
                end
            end
            // ----------------------------------------
            // Self-timed cycles
            // ----------------------------------------
            case (st)
                ST_IDLE:
                begin
                end
                ST_PROG:
                begin
                    if (cnt == PROG_CYC)
                    begin
                        for (i = 0; i < 256; i = i + 1)
                            if (pmask[i])
                                mem[{addr[AW-1:8], i[7:0]}] <= mem[{addr[AW-1:8], i[7:0]}] & pbuf[i]; // [R7]
                    end
                    cnt <= cnt - 32'd1;
                    if (cnt == 32'd1)
                    begin
                        write_unlock_latch_out <= 1'b0; // [R15]
                        st <= ST_IDLE;
                    end
                end
                ST_SECT, ST_BULK:
                begin
                    if (!clr_idx[AW] && (st == ST_BULK || clr_idx < (1 << (AW - SECT_BITS))))
                    begin
                        if (st == ST_BULK)
                            mem[clr_idx[AW-1:0]] <= 8'hff; // [R19]
                        else
                            mem[{wipe_addr[AW-1 -: SECT_BITS], clr_idx[AW-SECT_BITS-1:0]}] <= 8'hff; // [R17]
                        clr_idx <= clr_idx + 1'b1;
                    end
                    cnt <= cnt - 32'd1;
                    if (cnt <= 32'd1)
                    begin
                        write_unlock_latch_out <= 1'b0; // [R15]
                        st <= ST_IDLE;
                    end
                end
                ST_SLP:
                begin
                    cnt <= cnt - 32'd1;
                    if (cnt <= 32'd1)
                    begin
                        sleep_out <= 1'b1; // [R21]
                        st <= ST_IDLE;
                    end
                end
                default:
                    st <= ST_IDLE;
            endcase
        end
    end
endmodule

// ===== src/sfrpe_regs.vh
// Constants for the serial flash sequencer
// Notes on behaviour
// [R1] Fast read: opcode, three address bytes, one dummy byte, sampled on rising clock.
// [R2] After dummy byte, memory data shifts out one bit per falling clock edge.
// [R3] Read address increments per byte and wraps from top to zero.
// [R4] Select high ends a read at any time; output drive stops.
// [R5] Fast read or sleep during a busy cycle is rejected, cycle unaffected.
// [R6] Page write and wipes need the write unlock latch set beforehand.
// [R7] Page write only clears bits from one to zero.
// [R8] Host holds select low and sends opcode, address, then data bytes.
// [R9] Page write data past page end wraps to page start.
// [R10] More than 256 bytes: only the last 256 are programmed.
// [R11] Fewer than 256 bytes: other bytes in the page stay unchanged.
// [R12] Page write runs only if select rises on a data byte boundary.
// [R13] Valid page write starts a self-timed program cycle at select rise.
// [R14] Cycle active flag is one during program or erase, zero after.
// [R15] Write unlock latch clears before program or erase cycle completes.
// [R16] Page write to a guarded page is not executed.
// [R17] Zone wipe takes opcode plus address and sets its whole sector to ones.
// [R18] Zone wipe runs only if select rises after last address byte; guarded skipped.
// [R19] Full array wipe is opcode only, select rises after eighth bit.
// [R20] Full array wipe runs only when all area guard bits are zero.
// [R21] Sleep is opcode only, select rises after eighth bit, enters after delay.
// [R22] In sleep only the wake command is honoured; reset leaves sleep.
// [R23] Select high gives standby only when no internal cycle runs.
// [R24] All bytes shift most significant bit first; opcodes are parameters.
`ifndef SFRPE_REGS_VH
`define SFRPE_REGS_VH
`define SFRPE_OP_FAST_READ   8'h0b
`define SFRPE_OP_PAGE_WRITE  8'h02
`define SFRPE_OP_ZONE_WIPE   8'hd8
`define SFRPE_OP_FULL_WIPE   8'hc7
`define SFRPE_OP_SLEEP       8'hb9
`define SFRPE_OP_WAKE        8'hab
`define SFRPE_OP_UNLOCK      8'h06
`define SFRPE_CLK_MHZ        100
`define SFRPE_T_PROG_US      2000
`define SFRPE_T_SECT_US      2000000
`define SFRPE_T_BULK_US      10000000
`define SFRPE_T_SLEEP_US     3
`define SFRPE_SLEEP_CYC      (`SFRPE_T_SLEEP_US * `SFRPE_CLK_MHZ)
`endif

// ===== src/sfrpe_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sfrpe_sync
(
    input  wire clk_in,
    input  wire reset_in,
    input  wire async_in,
    input  wire init_in,
    output reg  level_out
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk_in)
    begin
        if (reset_in)
        begin
            // Start at the pin's idle level so no false edge follows reset
            s1 <= init_in;
            s2 <= init_in;
            s3 <= init_in;
            level_out <= init_in;
        end
        else
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level_out <= s3;
        end
    end
endmodule

// ===== dv/sfrpe_asserts.sv
// Port checks for the flash sequencer
`timescale 1ns/1ps
module sfrpe_asserts
(
    input wire       clk_in,
    input wire       reset_in,
    input wire       sel_n_in,
    input wire       sclk_in,
    input wire       sdi_in,
    input wire [2:0] area_guard_bits_in,
    input wire       sdo_out,
    input wire       sdo_oe_out,
    input wire       cycle_active_flag_out,
    input wire       write_unlock_latch_out,
    input wire       sleep_out,
    input wire       standby_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    property p_sel_off; sel_n_in [*6] |-> !sdo_oe_out; endproperty
    a_sel_off: assert property (p_sel_off) else $error("drive while deselected");
    property p_sdo_edge; sdo_oe_out && $changed(sdo_out) |-> !sclk_in && !$past(sclk_in, 2); endproperty
    a_sdo_edge: assert property (p_sdo_edge) else $error("data moved off falling clock");
    property p_oe_start; $rose(sdo_oe_out) |-> !sel_n_in && !cycle_active_flag_out; endproperty
    a_oe_start: assert property (p_oe_start) else $error("read while busy");
    property p_run_latch; $rose(cycle_active_flag_out) |-> $past(write_unlock_latch_out); endproperty
    a_run_latch: assert property (p_run_latch) else $error("cycle without latch");
    property p_run_sel; $rose(cycle_active_flag_out) |-> $past(sel_n_in, 3) ##1 cycle_active_flag_out [*7]; endproperty
    a_run_sel: assert property (p_run_sel) else $error("cycle start or length");
    property p_latch_clr; $fell(cycle_active_flag_out) |-> !write_unlock_latch_out; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch kept after cycle");
    property p_standby; standby_out |-> !cycle_active_flag_out && !sleep_out; endproperty
    a_standby: assert property (p_standby) else $error("standby while active");
    property p_sleep; sleep_out |-> !cycle_active_flag_out && !$rose(write_unlock_latch_out); endproperty
    a_sleep: assert property (p_sleep) else $error("command taken in sleep");
endmodule
bind sfrpe_top sfrpe_asserts i_chk (.clk_in, .reset_in, .sel_n_in, .sclk_in, .sdi_in, .area_guard_bits_in,
    .sdo_out, .sdo_oe_out, .cycle_active_flag_out, .write_unlock_latch_out, .sleep_out, .standby_out);

// ===== dv/sfrpe_host.sv
// Host side serial master model
`timescale 1ns/1ps
module sfrpe_host
(
    input  wire  clk_in,
    input  wire  sdo_in,
    input  wire  sdo_oe_in,
    output logic sel_n_out = 1'b1,
    output logic sclk_out = 1'b0,
    output logic sdi_out = 1'b0
);
    logic [7:0] got [$];
    // ----------------------------------------
    // Frame tasks, clock still outside frames
    // ----------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--)
        begin
            sdi_out <= tx[i];
            wait_clk(8);
            sclk_out <= 1'b1;
            rx = {rx[6:0], sdo_oe_in ? sdo_in : 1'bx};
            wait_clk(8);
            sclk_out <= 1'b0;
        end
    endtask
    task automatic cmd(input logic [7:0] q [$], input int nrd, input int tail = 8);
        logic [7:0] r;
        got = {};
        sel_n_out <= 1'b0;
        wait_clk(8);
        foreach (q[k]) xfer(q[k], (k == q.size() - 1) ? tail : 8, r);
        repeat (nrd)
        begin
            xfer(8'hff, 8, r);
            got.push_back(r);
        end
        wait_clk(8);
        sel_n_out <= 1'b1;
        sdi_out <= ~sdi_out;
        wait_clk(12);
    endtask
endmodule

// ===== dv/sfrpe_top_tb.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`include "sfrpe_regs.vh"
module sfrpe_top_tb;
    logic       clk_in = 1'b0;
    logic       reset_in = 1'b1;
    logic [2:0] guard = 3'h0;
    wire        sel_n, sclk, sdi, sdo, sdo_oe, busy, latch, sleep, standby;
    int         n_fail = 0;
    int         n_compared = 0;
    int         cyc = 0;
    always #5 clk_in = ~clk_in;
    sfrpe_top #(.AW(12), .PROG_CYC(50), .SECT_CYC(256), .BULK_CYC(4096)) i_dut
    (
        .clk_in(clk_in), .reset_in(reset_in), .sel_n_in(sel_n), .sclk_in(sclk), .sdi_in(sdi),
        .area_guard_bits_in(guard), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .cycle_active_flag_out(busy),
        .write_unlock_latch_out(latch), .sleep_out(sleep), .standby_out(standby)
    );
    sfrpe_host i_host (.clk_in(clk_in), .sdo_in(sdo), .sdo_oe_in(sdo_oe), .sel_n_out(sel_n),
        .sclk_out(sclk), .sdi_out(sdi));
    // ----------------------------------------
    // Shared checking and command tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic wait_idle;
        for (int i = 0; i < 6000 && busy !== 1'b0; i++) @(posedge clk_in);
        check("idle flag", busy, 8'h00);
    endtask
    task automatic rd(input logic [23:0] a, input logic [7:0] e [$]);
        i_host.cmd({`SFRPE_OP_FAST_READ, a[23:16], a[15:8], a[7:0], 8'h00}, e.size());
        foreach (e[k]) check("read byte", i_host.got[k], e[k]);
    endtask
    task automatic wr(input logic [7:0] q [$], input logic run, input int tail = 8);
        i_host.cmd({`SFRPE_OP_UNLOCK}, 0);
        check("unlock latch", latch, 8'h01);
        i_host.cmd(q, 0, tail);
        check("cycle start", busy, run);
        wait_idle();
        if (run)
            check("latch clear", latch, 8'h00);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_page;
        check("standby", standby, 8'h01);
        check("flags", {busy, latch, sleep, sdo_oe}, 8'h00);
        i_host.cmd({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h00, 8'h40, 8'h00}, 0);
        check("locked write", busy, 8'h00);
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h00, 8'hfe, 8'h11, 8'h22, 8'h33}, 1'b1);
        rd(24'h0000fe, {8'h11, 8'h22, 8'hff});
        rd(24'h000fff, {8'hff, 8'h33, 8'hff});
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'ha5}, 1'b1);
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'h5a, 8'h77}, 1'b0, 4);
        rd(24'h000010, {8'ha5});
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h00, 8'h10, 8'h5a}, 1'b1);
        rd(24'h000010, {8'h00});
        $display("page write test done");
    endtask
    task automatic t_guard;
        guard <= 3'h1;
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h0f, 8'h00, 8'h00}, 1'b0);
        wr({`SFRPE_OP_ZONE_WIPE, 8'h00, 8'h0f, 8'h80}, 1'b0);
        wr({`SFRPE_OP_FULL_WIPE}, 1'b0);
        wr({`SFRPE_OP_ZONE_WIPE, 8'h00, 8'h00, 8'hab}, 1'b1);
        rd(24'h000010, {8'hff});
        guard <= 3'h0;
        wr({`SFRPE_OP_PAGE_WRITE, 8'h00, 8'h03, 8'h00, 8'h00}, 1'b1);
        $display("guard and wipe test done");
    endtask
    task automatic t_busy;
        i_host.cmd({`SFRPE_OP_UNLOCK}, 0);
        i_host.cmd({`SFRPE_OP_FULL_WIPE}, 0);
        check("bulk start", busy, 8'h01);
        rd(24'h000300, {8'hxx});
        i_host.cmd({`SFRPE_OP_SLEEP}, 0);
        i_host.wait_clk(320);
        check("sleep while busy", {sleep, busy}, 8'h01);
        wait_idle();
        rd(24'h000300, {8'hff});
        $display("busy test done");
    endtask
    task automatic t_sleep;
        i_host.cmd({`SFRPE_OP_SLEEP}, 0);
        i_host.wait_clk(320);
        check("sleep entry", {sleep, standby}, 8'h02);
        i_host.cmd({`SFRPE_OP_UNLOCK}, 0);
        check("unlock in sleep", latch, 8'h00);
        i_host.cmd({`SFRPE_OP_WAKE}, 0);
        check("wake", {sleep, standby}, 8'h01);
        $display("sleep test done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (6) @(posedge clk_in);
        t_page();
        t_guard();
        t_busy();
        t_sleep();
        give_verdict();
    end
endmodule
